/* File: dv/dbm_mapper_chk.sv */
// port assertions for the dual-bus pdu mapper
`timescale 1ns/1ps
module dbm_mapper_chk (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // watched ports
  input wire logic tx_req_valid_in,
  input wire logic tx_req_ready_out,
  input wire logic tx_pay_ready_out,
  input wire logic seg_valid_out,
  input wire logic [31:0] seg_data_out,
  input wire logic seg_ready_in,
  input wire logic rx_valid_in,
  input wire logic [31:0] rx_data_in,
  input wire logic rx_sdu_valid_out,
  input wire logic [31:0] rx_sdu_out,
  input wire logic ind_valid_out,
  input wire dbm_pkg::dbm_ind_s ind_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  ////////////////////////////////////////////////////////////////////////
  // transmit side
  seg_hold_a: assert property (
    seg_valid_out && !seg_ready_in |=> seg_valid_out && $stable(seg_data_out))
    else $error("seg word dropped or changed while stalled");
  req_busy_a: assert property (
    tx_req_valid_in && tx_req_ready_out |=> !tx_req_ready_out)
    else $error("request ready stayed high after take");
  first_word_a: assert property (
    tx_req_valid_in && tx_req_ready_out |-> ##2 seg_valid_out)
    else $error("first pdu word late");
  pay_phase_a: assert property (
    tx_pay_ready_out |-> !tx_req_ready_out)
    else $error("payload taken while idle");

  ////////////////////////////////////////////////////////////////////////
  // receive side
  ind_kind_a: assert property (
    ind_valid_out |-> ind_out.user_data && ind_out.no_response)
    else $error("indication kind wrong");
  fcs_unspec_a: assert property (
    ind_valid_out && !ind_out.fcs_known |-> ind_out.fcs == 32'h0000_0000)
    else $error("unspecified fcs not zero");
  ind_pulse_a: assert property (
    ind_valid_out |=> !ind_valid_out)
    else $error("indication longer than one cycle");
  ind_cause_a: assert property (
    ind_valid_out |-> $past(rx_valid_in))
    else $error("indication without trailer word");
  sdu_echo_a: assert property (
    rx_sdu_valid_out |-> $past(rx_valid_in) && rx_sdu_out == $past(rx_data_in))
    else $error("sdu word not echoed from payload");

  // main scenarios reached
  stall_c: cover property (seg_valid_out && !seg_ready_in);
  take_c: cover property (tx_req_valid_in && tx_req_ready_out);
  ind_c: cover property (ind_valid_out && ind_out.fcs_known);
endmodule : dbm_mapper_chk

bind dbm_mapper dbm_mapper_chk chk_u (
  .clk_in(clk_in), .nrst_in(nrst_in), .tx_req_valid_in(tx_req_valid_in),
  .tx_req_ready_out(tx_req_ready_out), .tx_pay_ready_out(tx_pay_ready_out),
  .seg_valid_out(seg_valid_out), .seg_data_out(seg_data_out),
  .seg_ready_in(seg_ready_in), .rx_valid_in(rx_valid_in),
  .rx_data_in(rx_data_in), .rx_sdu_valid_out(rx_sdu_valid_out),
  .rx_sdu_out(rx_sdu_out), .ind_valid_out(ind_valid_out), .ind_out(ind_out)
);

/* File: dv/dbm_seg_model.sv */
// segmentation-side sink model with optional stalls
`timescale 1ns/1ps
module dbm_seg_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // stall control
  input wire logic slow_in,
  // pdu words from the mapper
  input wire logic seg_valid_in,
  input wire logic [31:0] seg_data_in,
  output logic seg_ready_out
);
  logic [31:0] words[$];

  ////////////////////////////////////////////////////////////////////////
  // take a word on valid and ready; slow mode stalls every other cycle
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      seg_ready_out <= 1'b0;
    end else begin
      if (seg_valid_in && seg_ready_out) begin
        words.push_back(seg_data_in);
      end
      seg_ready_out <= slow_in ? !seg_ready_out : 1'b1;
    end
  end
endmodule : dbm_seg_model

/* File: dv/test_dual_bus_bridge_pdu_mapper.sv */
// self-checking bench for the dual-bus pdu mapper
`timescale 1ns/1ps
module test_dual_bus_bridge_pdu_mapper;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic crc_gen_en_in = 1'b0;
  logic tx_req_valid_in = 1'b0;
  dbm_pkg::dbm_req_s tx_req_in = '0;
  logic tx_pay_valid_in = 1'b0;
  logic [31:0] tx_pay_in = 32'h0000_0000;
  logic rx_valid_in = 1'b0;
  logic [31:0] rx_data_in = 32'h0000_0000;
  logic rx_last_in = 1'b0;
  logic slow = 1'b0;
  logic tx_req_ready_out, tx_pay_ready_out, seg_valid_out, seg_ready_in;
  logic rx_sdu_valid_out, rx_sdu_last_out, ind_valid_out;
  logic [31:0] seg_data_out, rx_sdu_out;
  dbm_pkg::dbm_ind_s ind_out;
  dbm_pkg::dbm_req_s r;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_ind = 0;
  int n_last = 0;
  logic [7:0] betag = 8'h00;
  logic [31:0] sdu_q[$];

  ////////////////////////////////////////////////////////////////////////
  // clock, design and far-side model
  initial forever #2 clk_in = ~clk_in;
  dbm_mapper dut_u (
    .clk_in(clk_in), .nrst_in(nrst_in), .crc_gen_en_in(crc_gen_en_in),
    .tx_req_valid_in(tx_req_valid_in), .tx_req_in(tx_req_in),
    .tx_req_ready_out(tx_req_ready_out), .tx_pay_valid_in(tx_pay_valid_in),
    .tx_pay_in(tx_pay_in), .tx_pay_ready_out(tx_pay_ready_out),
    .seg_valid_out(seg_valid_out), .seg_data_out(seg_data_out),
    .seg_ready_in(seg_ready_in), .rx_valid_in(rx_valid_in),
    .rx_data_in(rx_data_in), .rx_last_in(rx_last_in),
    .rx_sdu_valid_out(rx_sdu_valid_out), .rx_sdu_out(rx_sdu_out),
    .rx_sdu_last_out(rx_sdu_last_out), .ind_valid_out(ind_valid_out),
    .ind_out(ind_out));
  dbm_seg_model seg_u (
    .clk_in(clk_in), .nrst_in(nrst_in), .slow_in(slow),
    .seg_valid_in(seg_valid_out), .seg_data_in(seg_data_out),
    .seg_ready_out(seg_ready_in));

  // collect echoed sdu words and indications; cut a hang short
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (rx_sdu_valid_out === 1'b1) sdu_q.push_back(rx_sdu_out);
    if (ind_valid_out === 1'b1) n_ind <= n_ind + 1;
    if (rx_sdu_last_out === 1'b1) n_last <= n_last + 1;
    if (cycles == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic check(input string what, input logic [47:0] exp,
                       input logic [47:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // crc32 msb first, own copy so a shared slip cannot hide
  function automatic logic [31:0] crc_step(input logic [31:0] c,
                                           input logic [31:0] d);
    for (int i = 31; i >= 0; i--) begin
      c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? 32'h04C1_1DB7 : 32'h0);
    end
    return c;
  endfunction : crc_step

  ////////////////////////////////////////////////////////////////////////
  // transmit one request and compare every pdu word
  task automatic send_pdu(input dbm_pkg::dbm_req_s q, input logic crc_en,
                          input logic slow_en);
    logic [31:0] exp[$];
    logic [31:0] w, c;
    logic [15:0] bas;
    logic [2:0] xl;
    logic [1:0] pad;
    logic ci;
    int nw;
    nw = (q.len + 3) / 4;
    ci = q.fcs_valid | crc_en;
    xl = q.hext_present ? q.ext_len : 3'h0;
    pad = 2'(4 - q.len % 4);
    bas = 16'(20 + 4 * xl + 4 * nw + 4 * ci);
    exp = '{{8'h00, betag, bas}, {4'h8, 12'h000, q.da[47:32]}, q.da[31:0],
            {4'h8, 12'h000, q.sa[47:32]}, q.sa[31:0],
            {6'h01, pad, q.prio, 1'b0, ci, xl, 16'h0000}};
    for (int i = 0; i < xl; i++) exp.push_back(q.hext[i]);
    for (int i = 0; i < nw; i++) begin
      w = 32'hC35A_0000 | i;
      if (i == nw - 1 && q.len[1:0] != 2'b00) begin
        w = w & ~(32'hFFFF_FFFF >> (8 * q.len[1:0])); // pad bytes are zero
      end
      exp.push_back(w);
    end
    c = 32'hFFFF_FFFF;
    for (int k = 1; k < exp.size(); k++) c = crc_step(c, exp[k]);
    if (q.fcs_valid) exp.push_back(q.fcs);
    else if (crc_en) exp.push_back(~c);
    exp.push_back({8'h00, betag, bas});
    betag++;
    seg_u.words.delete();
    slow <= slow_en;
    crc_gen_en_in <= crc_en;
    tx_req_in <= q;
    tx_req_valid_in <= 1'b1;
    do @(posedge clk_in); while (tx_req_ready_out !== 1'b1);
    tx_req_valid_in <= 1'b0;
    for (int i = 0; i < nw; i++) begin
      tx_pay_valid_in <= 1'b1;
      tx_pay_in <= 32'hC35A_0000 | i; // junk in pad bytes on purpose
      do @(posedge clk_in); while (tx_pay_ready_out !== 1'b1);
    end
    tx_pay_valid_in <= 1'b0;
    while (seg_u.words.size() < exp.size()) @(posedge clk_in);
    foreach (exp[k]) check("pdu word", exp[k], seg_u.words[k]);
  endtask : send_pdu

  ////////////////////////////////////////////////////////////////////////
  // feed one received pdu and judge sdu and indication
  task automatic recv_pdu(input logic [3:0] t_da, input logic [3:0] t_sa,
                          input logic ci, input logic [15:0] len,
                          input logic [2:0] xl);
    logic [31:0] w[$];
    logic [31:0] pay[$];
    logic [15:0] bas;
    logic [1:0] pad;
    logic good;
    int nw, ni, nl;
    nw = (len + 3) / 4;
    pad = 2'(4 - len % 4);
    // size field must match what follows, or the parser miscounts words
    bas = 16'(20 + 4 * xl + 4 * nw + 4 * ci);
    good = (t_da == 4'h8) && (t_sa == 4'h8);
    w = '{{16'h0000, bas}, {t_da, 12'h000, 16'h1122}, 32'h3344_5566,
          {t_sa, 12'h000, 16'h7788}, 32'h99AA_BBCC,
          {6'h01, pad, 3'h5, 1'b0, ci, xl, 16'h0000}};
    for (int i = 0; i < xl; i++) w.push_back(32'hE0E0_0000 | i);
    for (int i = 0; i < nw; i++) pay.push_back(32'h1357_0000 | i);
    w = {w, pay};
    if (ci) w.push_back(32'hDEAD_BEEF);
    w.push_back({16'h0000, bas});
    sdu_q.delete();
    ni = n_ind;
    nl = n_last;
    foreach (w[k]) begin
      rx_valid_in <= 1'b1;
      rx_data_in <= w[k];
      rx_last_in <= (k == w.size() - 1);
      @(posedge clk_in);
    end
    rx_valid_in <= 1'b0;
    rx_last_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    check("ind count", good, n_ind - ni);
    check("sdu count", good ? nw : 0, sdu_q.size());
    check("sdu last", good, n_last - nl);
    if (good) begin
      foreach (pay[k]) check("sdu word", pay[k], sdu_q[k]);
      check("ind da", 48'h1122_3344_5566, ind_out.da);
      check("ind sa", 48'h7788_99AA_BBCC, ind_out.sa);
      check("ind len", len, ind_out.len);
      check("ind prio", 3'h5, ind_out.prio);
      check("ind ext len", xl, ind_out.ext_len);
      check("ind ext", xl ? 32'hE0E0_0000 : 0, ind_out.hext[0]);
      check("fcs known", ci, ind_out.fcs_known);
      check("ind fcs", ci ? 32'hDEAD_BEEF : 32'h0, ind_out.fcs);
    end
  endtask : recv_pdu

  ////////////////////////////////////////////////////////////////////////
  // closing report
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  // main sequence: reset, three transmits back to back, four receives
  initial begin
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    r = '0;
    r.da = 48'h0A1B_2C3D_4E5F;
    r.sa = 48'h0607_0809_0A0B;
    r.prio = 3'h6;
    r.fcs_valid = 1'b1;
    r.fcs = 32'h1234_5678;
    r.len = 16'h0005;
    send_pdu(r, 1'b0, 1'b1);
    r.fcs_valid = 1'b0;
    r.len = 16'h0008;
    r.hext_present = 1'b1;
    r.ext_len = 3'h2;
    r.hext[0] = 32'hA5A5_0001;
    r.hext[1] = 32'h5A5A_0002;
    send_pdu(r, 1'b1, 1'b0);
    r.hext_present = 1'b0;
    r.len = 16'h0003;
    send_pdu(r, 1'b0, 1'b1);
    recv_pdu(4'h8, 4'h8, 1'b1, 16'h0006, 3'h0);
    recv_pdu(4'h8, 4'h8, 1'b0, 16'h0004, 3'h2);
    recv_pdu(4'h9, 4'h8, 1'b1, 16'h0004, 3'h0);
    recv_pdu(4'h8, 4'h2, 1'b0, 16'h0004, 3'h0);
    tally_and_finish();
  end
endmodule : test_dual_bus_bridge_pdu_mapper

/* File: rtl/dbm_buf2.sv */
// two-entry skid buffer between the framer and segmentation
`timescale 1ns/1ps
module dbm_buf2 #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // fill side
  input wire logic in_valid_in,
  input wire logic [W-1:0] in_data_in,
  output logic in_ready_out,
  output logic [1:0] cnt_next_out,
  // drain side
  output logic out_valid_out,
  output logic [W-1:0] out_data_out,
  input wire logic out_ready_in
);

  logic [1:0][W-1:0] mem_reg, mem_next;
  logic wr_reg, wr_next, rd_reg, rd_next;
  logic [1:0] cnt_reg, cnt_next;
  logic valid_reg, valid_next;
  logic [W-1:0] dout_reg, dout_next;
  logic push, pop;

  ////////////////////////////////////////////////////////////////////////
  // pointer and count update; pop only while a word is shown
  always_comb begin
    push = in_valid_in && (cnt_reg != 2'(dbm_pkg::BUF_DEPTH));
    pop = valid_reg && out_ready_in;
    mem_next = mem_reg;
    wr_next = wr_reg;
    rd_next = rd_reg;
    if (push) begin
      mem_next[wr_reg] = in_data_in;
      wr_next = ~wr_reg;
    end
    if (pop) begin
      rd_next = ~rd_reg;
    end
    cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
    valid_next = cnt_next != 2'h0;
    // head word kept in its own flop so the port needs no mux
    dout_next = mem_next[rd_next];
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mem_reg <= '0;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      cnt_reg <= 2'h0;
      valid_reg <= 1'b0;
      dout_reg <= '0;
    end else begin
      mem_reg <= mem_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      valid_reg <= valid_next;
      dout_reg <= dout_next;
    end
  end

  assign in_ready_out = cnt_reg != 2'(dbm_pkg::BUF_DEPTH);
  assign cnt_next_out = cnt_next;
  assign out_valid_out = valid_reg;
  assign out_data_out = dout_reg; // held until popped

endmodule : dbm_buf2

/* File: rtl/dbm_mapper.sv */
// pdu framer and parser between bridge relay and dual-bus segmentation
`timescale 1ns/1ps
module dbm_mapper (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // configuration
  input wire logic crc_gen_en_in,
  // transmit request
  input wire logic tx_req_valid_in,
  input wire dbm_pkg::dbm_req_s tx_req_in,
  output logic tx_req_ready_out,
  // transmit payload words
  input wire logic tx_pay_valid_in,
  input wire logic [31:0] tx_pay_in,
  output logic tx_pay_ready_out,
  // pdu words to segmentation
  output logic seg_valid_out,
  output logic [31:0] seg_data_out,
  input wire logic seg_ready_in,
  // pdu words from reassembly
  input wire logic rx_valid_in,
  input wire logic [31:0] rx_data_in,
  input wire logic rx_last_in,
  // indicated payload and parameters
  output logic rx_sdu_valid_out,
  output logic [31:0] rx_sdu_out,
  output logic rx_sdu_last_out,
  output logic ind_valid_out,
  output dbm_pkg::dbm_ind_s ind_out
);

  ////////////////////////////////////////////////////////////////////////
  // crc32, msb first, one word per step
  function automatic logic [31:0] crc_step(input logic [31:0] c,
                                           input logic [31:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      r = (r[31] ^ d[i]) ? ((r << 1) ^ dbm_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc_step

  ////////////////////////////////////////////////////////////////////////
  // transmit state
  typedef enum logic [5:0] {
    T_IDLE = 6'b000001,
    T_HDR = 6'b000010,
    T_EXT = 6'b000100,
    T_PAY = 6'b001000,
    T_CRC = 6'b010000,
    T_TRL = 6'b100000
  } dbm_tx_e;

  dbm_tx_e tst_reg, tst_next;
  dbm_pkg::dbm_req_s req_reg, req_next;
  logic [2:0] tidx_reg, tidx_next;
  logic [15:0] tleft_reg, tleft_next;
  logic [15:0] basize_reg, basize_next;
  logic [31:0] crc_reg, crc_next;
  logic [7:0] betag_reg, betag_next;
  logic crc_ind_reg, crc_ind_next;
  logic pay_rdy_reg, pay_rdy_next;
  logic req_rdy_reg, req_rdy_next;
  logic [31:0] word;
  logic push, room;
  logic [1:0] pad_len, cnt_next;
  logic [15:0] words;
  logic [31:0] mask;

  // pad bytes fill the last payload word up to a word boundary
  assign pad_len = 2'h0 - req_reg.len[1:0];

  ////////////////////////////////////////////////////////////////////////
  // transmit word builder and sequencer
  always_comb begin
    tst_next = tst_reg;
    req_next = req_reg;
    tidx_next = tidx_reg;
    tleft_next = tleft_reg;
    basize_next = basize_reg;
    crc_next = crc_reg;
    betag_next = betag_reg;
    crc_ind_next = crc_ind_reg;
    word = dbm_pkg::WORD_RESET;
    push = 1'b0;
    words = 16'h0000;
    unique case (pad_len)
      2'h0: mask = 32'hFFFF_FFFF;
      2'h1: mask = 32'hFFFF_FF00;
      2'h2: mask = 32'hFFFF_0000;
      2'h3: mask = 32'hFF00_0000;
    endcase
    unique case (tst_reg)
      T_IDLE: begin
        if (tx_req_valid_in && req_rdy_reg) begin
          req_next = tx_req_in;
          if (!tx_req_in.hext_present) begin
            req_next.ext_len = 3'h0;
            req_next.hext = '0;
          end
          crc_ind_next = tx_req_in.fcs_valid || crc_gen_en_in;
          words = 16'((17'(tx_req_in.len) + 17'h3) >> 2);
          tleft_next = words;
          basize_next = dbm_pkg::CONV_HDR_BYTES + (16'(req_next.ext_len) << 2)
                      + (words << 2) + (crc_ind_next ? 16'h0004 : 16'h0000);
          crc_next = dbm_pkg::CRC_INIT;
          tidx_next = 3'h0;
          tst_next = T_HDR;
        end
      end
      T_HDR: begin
        unique case (tidx_reg)
          3'h0: word = {dbm_pkg::RSVD_ZERO, betag_reg, basize_reg};
          3'h1: word = {dbm_pkg::ADDR_TYPE_48, dbm_pkg::ADDR_PAD,
                        req_reg.da[47:32]};
          3'h2: word = req_reg.da[31:0];
          3'h3: word = {dbm_pkg::ADDR_TYPE_48, dbm_pkg::ADDR_PAD,
                        req_reg.sa[47:32]};
          3'h4: word = req_reg.sa[31:0];
          default: word = {dbm_pkg::PROTO_LLC, pad_len,
                           req_reg.prio, dbm_pkg::LOSS_ZERO,
                           crc_ind_reg, req_reg.ext_len,
                           dbm_pkg::BRIDGING_ZERO};
        endcase
        push = room;
        if (push) begin
          tidx_next = tidx_reg + 3'h1;
          if (tidx_reg == dbm_pkg::HDR_LAST_IDX) begin
            tidx_next = 3'h0;
            tst_next = (req_reg.ext_len != 3'h0) ? T_EXT :
                       (tleft_reg != 16'h0000) ? T_PAY :
                       crc_ind_reg ? T_CRC : T_TRL;
          end
        end
      end
      T_EXT: begin
        word = req_reg.hext[tidx_reg];
        push = room;
        if (push) begin
          tidx_next = tidx_reg + 3'h1;
          if (tidx_next == req_reg.ext_len) begin
            tidx_next = 3'h0;
            tst_next = (tleft_reg != 16'h0000) ? T_PAY :
                       crc_ind_reg ? T_CRC : T_TRL;
          end
        end
      end
      T_PAY: begin
        // pad bytes forced to zero in the last word
        word = (tleft_reg == 16'h0001) ? (tx_pay_in & mask) : tx_pay_in;
        push = tx_pay_valid_in && pay_rdy_reg;
        if (push) begin
          tleft_next = tleft_reg - 16'h0001;
          if (tleft_reg == 16'h0001) begin
            tst_next = crc_ind_reg ? T_CRC : T_TRL;
          end
        end
      end
      T_CRC: begin
        // supplied value wins over the computed one
        word = req_reg.fcs_valid ? req_reg.fcs : ~crc_reg;
        push = room;
        if (push) begin
          tst_next = T_TRL;
        end
      end
      T_TRL: begin
        word = {dbm_pkg::RSVD_ZERO, betag_reg, basize_reg};
        push = room;
        if (push) begin
          betag_next = betag_reg + 8'h01;
          tst_next = T_IDLE;
        end
      end
    endcase
    // crc covers convergence header through pad
    if (push && ((tst_reg == T_HDR && tidx_reg != 3'h0) ||
                 tst_reg == T_EXT || tst_reg == T_PAY)) begin
      crc_next = crc_step(crc_reg, word);
    end
    req_rdy_next = tst_next == T_IDLE;
    // payload ready only when the buffer surely has a slot next cycle
    pay_rdy_next = (tst_next == T_PAY) &&
                   (cnt_next != 2'(dbm_pkg::BUF_DEPTH));
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tst_reg <= T_IDLE;
      req_reg <= '0;
      tidx_reg <= 3'h0;
      tleft_reg <= 16'h0000;
      basize_reg <= 16'h0000;
      crc_reg <= dbm_pkg::CRC_INIT;
      betag_reg <= dbm_pkg::BETAG_RESET;
      crc_ind_reg <= 1'b0;
      pay_rdy_reg <= 1'b0;
      req_rdy_reg <= 1'b0;
    end else begin
      tst_reg <= tst_next;
      req_reg <= req_next;
      tidx_reg <= tidx_next;
      tleft_reg <= tleft_next;
      basize_reg <= basize_next;
      crc_reg <= crc_next;
      betag_reg <= betag_next;
      crc_ind_reg <= crc_ind_next;
      pay_rdy_reg <= pay_rdy_next;
      req_rdy_reg <= req_rdy_next;
    end
  end

  assign tx_req_ready_out = req_rdy_reg;
  assign tx_pay_ready_out = pay_rdy_reg;

  ////////////////////////////////////////////////////////////////////////
  // output buffer; a stalled segmenter backs up into the sequencer
  dbm_buf2 #(
    .W(dbm_pkg::WORD_W)
  ) u_buf (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .in_valid_in(push),
    .in_data_in(word),
    .in_ready_out(room),
    .cnt_next_out(cnt_next),
    .out_valid_out(seg_valid_out),
    .out_data_out(seg_data_out),
    .out_ready_in(seg_ready_in)
  );

  ////////////////////////////////////////////////////////////////////////
  // receive state
  typedef enum logic [5:0] {
    R_HDR = 6'b000001,
    R_EXT = 6'b000010,
    R_PAY = 6'b000100,
    R_CRC = 6'b001000,
    R_TRL = 6'b010000,
    R_DROP = 6'b100000
  } dbm_rx_e;

  dbm_rx_e rst_reg, rst_next;
  dbm_pkg::dbm_ind_s ind_reg, ind_next;
  logic [2:0] ridx_reg, ridx_next;
  logic [15:0] rleft_reg, rleft_next;
  logic [15:0] rsize_reg, rsize_next;
  logic [1:0] rpl_reg, rpl_next;
  logic sv_reg, sv_next, sl_reg, sl_next, iv_reg, iv_next;
  logic [31:0] sd_reg, sd_next;
  logic [15:0] plw;

  ////////////////////////////////////////////////////////////////////////
  // receive parser; address check happens before any payload leaves
  always_comb begin
    rst_next = rst_reg;
    ind_next = ind_reg;
    ridx_next = ridx_reg;
    rleft_next = rleft_reg;
    rsize_next = rsize_reg;
    rpl_next = rpl_reg;
    sv_next = 1'b0;
    sl_next = 1'b0;
    sd_next = sd_reg;
    iv_next = 1'b0;
    plw = rsize_reg - dbm_pkg::CONV_HDR_BYTES
        - (16'(rx_data_in[18:16]) << 2)
        - (rx_data_in[19] ? 16'h0004 : 16'h0000);
    if (rx_valid_in) begin
      unique case (rst_reg)
        R_HDR: begin
          ridx_next = ridx_reg + 3'h1;
          unique case (ridx_reg)
            3'h0: rsize_next = rx_data_in[15:0];
            3'h1: begin
              ind_next.da[47:32] = rx_data_in[15:0];
              if (rx_data_in[31:28] != dbm_pkg::ADDR_TYPE_48) begin
                rst_next = R_DROP;
              end
            end
            3'h2: ind_next.da[31:0] = rx_data_in;
            3'h3: begin
              ind_next.sa[47:32] = rx_data_in[15:0];
              if (rx_data_in[31:28] != dbm_pkg::ADDR_TYPE_48) begin
                rst_next = R_DROP;
              end
            end
            3'h4: ind_next.sa[31:0] = rx_data_in;
            default: begin
              rpl_next = rx_data_in[25:24];
              ind_next.prio = rx_data_in[23:21];
              ind_next.fcs_known = rx_data_in[19];
              ind_next.ext_len = rx_data_in[18:16];
              ind_next.hext = '0;
              rleft_next = plw >> 2;
              ind_next.len = plw - 16'(rx_data_in[25:24]);
              ridx_next = 3'h0;
              rst_next = (rx_data_in[18:16] != 3'h0) ? R_EXT :
                         (rleft_next != 16'h0000) ? R_PAY :
                         rx_data_in[19] ? R_CRC : R_TRL;
            end
          endcase
        end
        R_EXT: begin
          ind_next.hext[ridx_reg] = rx_data_in; // kept for the indication
          ridx_next = ridx_reg + 3'h1;
          if (ridx_next == ind_reg.ext_len) begin
            ridx_next = 3'h0;
            rst_next = (rleft_reg != 16'h0000) ? R_PAY :
                       ind_reg.fcs_known ? R_CRC : R_TRL;
          end
        end
        R_PAY: begin
          sv_next = 1'b1;
          sd_next = rx_data_in;
          sl_next = rleft_reg == 16'h0001;
          rleft_next = rleft_reg - 16'h0001;
          if (rleft_reg == 16'h0001) begin
            rst_next = ind_reg.fcs_known ? R_CRC : R_TRL;
          end
        end
        R_CRC: begin
          ind_next.fcs = rx_data_in;
          rst_next = R_TRL;
        end
        R_TRL: begin
          iv_next = 1'b1;
          rst_next = R_HDR;
        end
        R_DROP: begin
          rst_next = R_DROP;
        end
      endcase
      // frame end outside the trailer ends the pdu without indication
      if (rx_last_in) begin
        rst_next = R_HDR;
        ridx_next = 3'h0;
      end
    end
    if (!ind_next.fcs_known) begin
      ind_next.fcs = 32'h0000_0000;
    end
    ind_next.user_data = 1'b1;
    ind_next.no_response = 1'b1;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_reg <= R_HDR;
      ind_reg <= dbm_pkg::IND_RESET;
      ridx_reg <= 3'h0;
      rleft_reg <= 16'h0000;
      rsize_reg <= 16'h0000;
      rpl_reg <= 2'h0;
      sv_reg <= 1'b0;
      sl_reg <= 1'b0;
      sd_reg <= dbm_pkg::WORD_RESET;
      iv_reg <= 1'b0;
    end else begin
      rst_reg <= rst_next;
      ind_reg <= ind_next;
      ridx_reg <= ridx_next;
      rleft_reg <= rleft_next;
      rsize_reg <= rsize_next;
      rpl_reg <= rpl_next;
      sv_reg <= sv_next;
      sl_reg <= sl_next;
      sd_reg <= sd_next;
      iv_reg <= iv_next;
    end
  end

  assign rx_sdu_valid_out = sv_reg;
  assign rx_sdu_out = sd_reg;
  assign rx_sdu_last_out = sl_reg;
  assign ind_valid_out = iv_reg;
  assign ind_out = ind_reg;

endmodule : dbm_mapper

/* File: rtl/dbm_pkg.sv */
// constants and carriers for the dual-bus pdu mapper
package dbm_pkg;

  ////////////////////////////////////////////////////////////////////////
  // field codes
  localparam logic [3:0] ADDR_TYPE_48 = 4'h8;
  localparam logic [11:0] ADDR_PAD = 12'h000;
  localparam logic [5:0] PROTO_LLC = 6'h01;
  localparam logic [15:0] BRIDGING_ZERO = 16'h0000;
  localparam logic [7:0] RSVD_ZERO = 8'h00;
  localparam logic LOSS_ZERO = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // sizes and counts
  localparam logic [15:0] CONV_HDR_BYTES = 16'h0014;
  localparam logic [2:0] HDR_LAST_IDX = 3'h5;
  localparam int EXT_MAX_WORDS = 5;
  localparam int BUF_DEPTH = 2;
  localparam int WORD_W = 32;

  ////////////////////////////////////////////////////////////////////////
  // crc32 and reset values
  localparam logic [31:0] CRC_POLY = 32'h04C1_1DB7;
  localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
  localparam logic [7:0] BETAG_RESET = 8'h00;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////
  // transmit request from the relay
  typedef struct packed {
    logic [47:0] da;
    logic [47:0] sa;
    logic [2:0] prio;
    logic fcs_valid;
    logic [31:0] fcs;
    logic [15:0] len;
    logic hext_present;
    logic [2:0] ext_len;
    logic [EXT_MAX_WORDS-1:0][31:0] hext;
  } dbm_req_s;

  // receive indication to the relay
  typedef struct packed {
    logic [47:0] da;
    logic [47:0] sa;
    logic [2:0] prio;
    logic fcs_known;
    logic [31:0] fcs;
    logic user_data;
    logic no_response;
    logic [15:0] len;
    logic [2:0] ext_len;
    logic [EXT_MAX_WORDS-1:0][31:0] hext;
  } dbm_ind_s;

  localparam dbm_ind_s IND_RESET = '0;

endpackage : dbm_pkg
